// ===== core/sscp_pkg.sv
package sscp_pkg;
  // clock and timing
  localparam longint unsigned CLK_HZ = 250_000_000;
  localparam longint unsigned SIGNON_TMO_S = 8;
  localparam longint unsigned SIGNON_TMO_CYC = SIGNON_TMO_S * CLK_HZ;
  localparam longint unsigned BAUD_BASE = 300;
  localparam longint unsigned DIV_BASE = CLK_HZ / BAUD_BASE;
  localparam int DIV_W = 20;
  localparam int TMO_W = 31;
  localparam logic [3:0] UART_STOP_BIT = 4'h9;
  // sign-on bytes
  localparam logic [7:0] TOK_RESET = 8'h9F;
  localparam logic [7:0] TOK_CANCEL = 8'h9E;
  localparam logic [7:0] TOK_SIGNON = 8'h88;
  localparam logic [7:0] TOK_NULL = 8'h00;
  localparam logic [7:0] REPLY_ASLEEP = 8'h80;
  localparam logic [7:0] REPLY_AWAKE = 8'h03;
  localparam logic [7:0] ERR_COMM = 8'hE1;
  localparam logic [7:0] ERR_PKT = 8'hE2;
  // polled command tokens
  localparam logic [7:0] TOK_CTL = 8'h01;
  localparam logic [7:0] TOK_AUX = 8'h02;
  localparam logic [7:0] TOK_FILT = 8'h03;
  localparam logic [7:0] TOK_AVG = 8'h04;
  localparam logic [7:0] TOK_EXP0 = 8'h06;
  localparam logic [7:0] TOK_EXP3 = 8'h09;
  localparam logic [7:0] TOK_RDIN = 8'h80;
  localparam logic [7:0] TOK_VER = 8'h86;
  localparam logic [7:0] TOK_CSUM = 8'h87;
  localparam logic [7:0] ARG_DIN = 8'h4C;
  // arbitrary value
  localparam logic [7:0] VERSION_ID = 8'h01;
  localparam logic [1:0] INIT_LAST_PKT = 2'h3;
  // register map and fields
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h04;
  localparam logic [7:0] REG_SETUP = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0C;
  localparam int CTRL_RST_BIT = 0;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  localparam logic [3:0] ISO_RST = 4'hF;
  localparam logic [2:0] BAUD_RST = 3'h0;

  typedef enum logic [2:0] {
    ST_SLEEP, ST_SIGNON, ST_BAUD, ST_ECHO, ST_INIT, ST_POLL
  } sscp_state_e;
  typedef enum logic [1:0] {AF_NONE, AF_BAUD, AF_BASE} sscp_after_e;

  function automatic logic [2:0] baud_shift(input logic [2:0] code);
    case (code)
      3'h1: baud_shift = 3'h2;
      3'h2: baud_shift = 3'h3;
      3'h3: baud_shift = 3'h4;
      3'h4: baud_shift = 3'h5;
      3'h5: baud_shift = 3'h6;
      default: baud_shift = 3'h0;
    endcase
  endfunction : baud_shift

  function automatic logic is_out_tok(input logic [7:0] t);
    is_out_tok = (t >= TOK_CTL && t <= TOK_AVG) ||
                 (t >= TOK_EXP0 && t <= TOK_EXP3);
  endfunction : is_out_tok

  function automatic logic is_req_tok(input logic [7:0] t);
    is_req_tok = t == TOK_RDIN || t == TOK_VER || t == TOK_CSUM;
  endfunction : is_req_tok
endpackage : sscp_pkg

// ===== core/sscp_uart_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sscp_uart_if;
  logic [sscp_pkg::DIV_W-1:0] div;
  logic rx_valid;
  logic [7:0] rx_data;
  logic tx_valid;
  logic [7:0] tx_data;
  logic tx_ready;
  modport uart (input div, tx_valid, tx_data,
                output rx_valid, rx_data, tx_ready);
  modport core (output div, tx_valid, tx_data,
                input rx_valid, rx_data, tx_ready);
endinterface : sscp_uart_if
`default_nettype wire

// ===== core/sscp_uart.sv
`timescale 1ns/1ps
`default_nettype none
module sscp_uart (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // serial pins
  input wire logic rxd,
  output logic txd,
  // core side
  sscp_uart_if.uart u
);
  localparam int DW = sscp_pkg::DIV_W;
  logic rx_busy_q;
  logic [DW-1:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic tx_busy_q;
  logic [DW-1:0] tx_cnt_q;
  logic [3:0] tx_bit_q;
  logic [8:0] tx_sh_q;

  // first sample lands mid start bit, later ones a bit period apart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
      u.rx_valid <= 1'b0;
      u.rx_data <= '0;
    end else begin
      u.rx_valid <= 1'b0;
      if (!rx_busy_q) begin
        if (!rxd) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q <= u.div >> 1;
          rx_bit_q <= '0;
        end
      end else if (rx_cnt_q != '0) begin
        rx_cnt_q <= rx_cnt_q - 1'b1;
      end else begin
        rx_cnt_q <= u.div - 1'b1;
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0 && rxd) begin
          rx_busy_q <= 1'b0;
        end else if (rx_bit_q == sscp_pkg::UART_STOP_BIT) begin
          rx_busy_q <= 1'b0;
          u.rx_valid <= rxd;
          u.rx_data <= rx_sh_q;
        end else if (rx_bit_q != 4'h0) begin
          rx_sh_q <= {rxd, rx_sh_q[7:1]};
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q <= '0;
      tx_bit_q <= '0;
      tx_sh_q <= '1;
      txd <= 1'b1;
      u.tx_ready <= 1'b1;
    end else if (!tx_busy_q) begin
      if (u.tx_valid) begin
        tx_busy_q <= 1'b1;
        u.tx_ready <= 1'b0;
        tx_sh_q <= {1'b1, u.tx_data};
        tx_cnt_q <= u.div - 1'b1;
        tx_bit_q <= '0;
        txd <= 1'b0;
      end
    end else if (tx_cnt_q != '0) begin
      tx_cnt_q <= tx_cnt_q - 1'b1;
    end else begin
      tx_cnt_q <= u.div - 1'b1;
      if (tx_bit_q == sscp_pkg::UART_STOP_BIT) begin
        tx_busy_q <= 1'b0;
        u.tx_ready <= 1'b1;
      end else begin
        txd <= tx_sh_q[0];
        tx_sh_q <= {1'b1, tx_sh_q[8:1]};
        tx_bit_q <= tx_bit_q + 4'h1;
      end
    end
  end
endmodule : sscp_uart
`default_nettype wire

// ===== core/sscp_core.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - after reset, wait about 8 s for serial input, then sleep.
// - reset answered with 0x80 when asleep, 0x03 in sign-on wait; in polled mode it returns to sign-on with no reply.
// - 0x88 plus baud code; code echoed at 300 baud, then rate switches.
// - link test echoes each byte; host waits for each echo.
// - 8 s silence in link test sends comm error, then sleep.
// - four init packets: two data bytes plus sum modulo 256.
// - first two packets hold converter setup, last two averaging, filter, mode.
// - three mode words are stored, read back and returned to host.
// - polled mode waits for packets with no inactivity timeout.
// - polled instruction is token, argument and checksum byte.
// - bad packet sends one error byte, then back to sign-on wait.
// - cancel and reset act at once; reset returns to sign-on.
// - cancel aborts a request mid-reply; host flushes partial replies.
// - eight output commands, no reply.
// - isolated port code bits turn transistors on, pulling lines low.
// - data requests resend the token, then one data byte.
// - control code: low 4 bits isolated port, next 3 channel, top ignored.
module sscp_core #(
  parameter longint unsigned TMO_CYC = sscp_pkg::SIGNON_TMO_CYC,
  parameter longint unsigned DIV_BASE = sscp_pkg::DIV_BASE
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // host serial link
  input wire logic rxd,
  output logic txd,
  // digital input and outputs
  input wire logic [7:0] din,
  output logic [3:0] iso_oe_n,
  output logic [2:0] chan,
  output logic [7:0] aux_out,
  output logic [7:0] exp_data,
  output logic [1:0] exp_sel,
  output logic exp_stb,
  output logic asleep
);
  localparam int DW = sscp_pkg::DIV_W;
  localparam int TW = sscp_pkg::TMO_W;
  localparam logic [TW-1:0] TMO_LAST = TW'(TMO_CYC - 1);

  sscp_pkg::sscp_state_e st_q;
  sscp_pkg::sscp_after_e after_q;
  logic [2:0] baud_q, code_q, resp_n_q, resp_i_q;
  logic [7:0] resp_q [4];
  logic ld_q, tx_go_q, sw_rst_q, scan_q;
  logic [7:0] tx_byte_q, csum_q, b0_q, b1_q;
  logic [1:0] pidx_q, pkt_q, filt_q;
  logic [3:0] avg_q;
  logic [23:0] mode_q;
  logic [TW-1:0] tmo_q;
  logic [7:0] aw_addr_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic aw_v_q, w_v_q;

  sscp_uart_if uif ();
  sscp_uart u_uart (
    .aclk(aclk),
    .aresetn(aresetn),
    .rxd(rxd),
    .txd(txd),
    .u(uif.uart)
  );

  // baud rate follows the agreed code
  assign uif.div = DW'(DIV_BASE >> sscp_pkg::baud_shift(baud_q));
  assign uif.tx_valid = tx_go_q;
  assign uif.tx_data = tx_byte_q;

  logic rx_v, done, tmo_hit, ev_rx, sum_ok, pkt_ok, init_ok, abort;
  logic [7:0] rx_d, psum;
  assign rx_v = uif.rx_valid;
  assign rx_d = uif.rx_data;
  assign psum = b0_q + b1_q;
  assign sum_ok = rx_d == psum;
  assign done = !ld_q && !tx_go_q && uif.tx_ready && resp_i_q >= resp_n_q;
  assign tmo_hit = tmo_q == TMO_LAST;
  assign ev_rx = rx_v && !sw_rst_q && !tmo_hit;
  // a cut landing in the launch cycle must not start one more byte
  assign abort = sw_rst_q || (rx_v && st_q == sscp_pkg::ST_POLL &&
                 pidx_q == 2'h0 && (rx_d == sscp_pkg::TOK_CANCEL ||
                 rx_d == sscp_pkg::TOK_RESET));
  assign pkt_ok = ev_rx && st_q == sscp_pkg::ST_POLL && done &&
                  pidx_q == 2'h2 && sum_ok;
  assign init_ok = ev_rx && st_q == sscp_pkg::ST_INIT &&
                   pidx_q == 2'h2 && sum_ok;

  // only sign-on wait and link test time out; polled mode never does
  always_ff @(posedge aclk) begin
    if (!aresetn || rx_v || !done ||
        !(st_q == sscp_pkg::ST_SIGNON || st_q == sscp_pkg::ST_ECHO)) begin
      tmo_q <= '0;
    end else begin
      tmo_q <= tmo_q + 1'b1;
    end
  end

  // reply sequencer; running checksum covers every byte sent after the null that ends the link test
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_go_q <= 1'b0;
      tx_byte_q <= '0;
      resp_i_q <= '0;
      csum_q <= '0;
    end else begin
      tx_go_q <= 1'b0;
      if (ld_q) begin
        resp_i_q <= '0;
      end else if (!tx_go_q && uif.tx_ready && !abort &&
                   resp_i_q < resp_n_q) begin
        tx_go_q <= 1'b1;
        tx_byte_q <= resp_q[resp_i_q[1:0]];
        resp_i_q <= resp_i_q + 3'h1;
        csum_q <= csum_q + resp_q[resp_i_q[1:0]];
      end
      if (ev_rx && st_q == sscp_pkg::ST_ECHO && rx_d == sscp_pkg::TOK_NULL)
        csum_q <= '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= sscp_pkg::ST_SIGNON;
      after_q <= sscp_pkg::AF_NONE;
      baud_q <= sscp_pkg::BAUD_RST;
      code_q <= '0;
      resp_q <= '{default: 8'h00};
      resp_n_q <= '0;
      ld_q <= 1'b0;
      pidx_q <= '0;
      pkt_q <= '0;
      b0_q <= '0;
      b1_q <= '0;
    end else begin
      ld_q <= 1'b0;
      // rate changes only once the last reply byte has left the line
      if (done && after_q != sscp_pkg::AF_NONE) begin
        baud_q <= after_q == sscp_pkg::AF_BAUD ? code_q : '0;
        after_q <= sscp_pkg::AF_NONE;
      end
      if (sw_rst_q) begin
        st_q <= sscp_pkg::ST_SIGNON;
        resp_n_q <= resp_i_q;
        baud_q <= '0;
        after_q <= sscp_pkg::AF_NONE;
        pidx_q <= '0;
      end else if (tmo_hit) begin
        if (st_q == sscp_pkg::ST_ECHO) begin
          resp_q[0] <= sscp_pkg::ERR_COMM;
          resp_n_q <= 3'h1;
          ld_q <= 1'b1;
          after_q <= sscp_pkg::AF_BASE;
        end
        st_q <= sscp_pkg::ST_SLEEP;
      end else if (rx_v) begin
        unique case (st_q)
          sscp_pkg::ST_SLEEP: begin
            if (rx_d == sscp_pkg::TOK_RESET) begin
              resp_q[0] <= sscp_pkg::REPLY_ASLEEP;
              resp_n_q <= 3'h1;
              ld_q <= 1'b1;
              st_q <= sscp_pkg::ST_SIGNON;
            end
          end
          sscp_pkg::ST_SIGNON: begin
            if (rx_d == sscp_pkg::TOK_RESET && done) begin
              resp_q[0] <= sscp_pkg::REPLY_AWAKE;
              resp_n_q <= 3'h1;
              ld_q <= 1'b1;
            end else if (rx_d == sscp_pkg::TOK_SIGNON) begin
              st_q <= sscp_pkg::ST_BAUD;
            end
          end
          sscp_pkg::ST_BAUD: begin
            code_q <= rx_d[2:0];
            resp_q[0] <= rx_d;
            resp_n_q <= 3'h1;
            ld_q <= 1'b1;
            after_q <= sscp_pkg::AF_BAUD;
            st_q <= sscp_pkg::ST_ECHO;
          end
          sscp_pkg::ST_ECHO: begin
            // one byte in flight at a time, the host waits for each echo
            if (done && rx_d == sscp_pkg::TOK_NULL) begin
              st_q <= sscp_pkg::ST_INIT;
              pidx_q <= '0;
              pkt_q <= '0;
            end else if (done) begin
              resp_q[0] <= rx_d;
              resp_n_q <= 3'h1;
              ld_q <= 1'b1;
            end
          end
          sscp_pkg::ST_INIT: begin
            if (pidx_q == 2'h0) b0_q <= rx_d;
            if (pidx_q == 2'h1) b1_q <= rx_d;
            pidx_q <= pidx_q == 2'h2 ? 2'h0 : pidx_q + 2'h1;
            if (pidx_q == 2'h2 && !sum_ok) begin
              resp_q[0] <= sscp_pkg::ERR_PKT;
              resp_n_q <= 3'h1;
              ld_q <= 1'b1;
              after_q <= sscp_pkg::AF_BASE;
              st_q <= sscp_pkg::ST_SIGNON;
            end else if (pidx_q == 2'h2) begin
              pkt_q <= pkt_q + 2'h1;
              if (pkt_q == sscp_pkg::INIT_LAST_PKT) begin
                resp_q[0] <= mode_q[23:16];
                resp_q[1] <= mode_q[15:8];
                resp_q[2] <= mode_q[7:0];
                resp_n_q <= 3'h3;
                ld_q <= 1'b1;
                st_q <= sscp_pkg::ST_POLL;
              end
            end
          end
          sscp_pkg::ST_POLL: begin
            if (pidx_q == 2'h0 && rx_d == sscp_pkg::TOK_RESET) begin
              st_q <= sscp_pkg::ST_SIGNON;
              resp_n_q <= resp_i_q;
              baud_q <= '0;
              after_q <= sscp_pkg::AF_NONE;
            end else if (pidx_q == 2'h0 && rx_d == sscp_pkg::TOK_CANCEL) begin
              resp_n_q <= resp_i_q;
            end else if (done) begin
              if (pidx_q == 2'h0) b0_q <= rx_d;
              if (pidx_q == 2'h1) b1_q <= rx_d;
              pidx_q <= pidx_q == 2'h2 ? 2'h0 : pidx_q + 2'h1;
              if (pidx_q == 2'h2) begin
                if (!sum_ok || !(sscp_pkg::is_req_tok(b0_q) ||
                                 sscp_pkg::is_out_tok(b0_q))) begin
                  resp_q[0] <= sscp_pkg::ERR_PKT;
                  resp_n_q <= 3'h1;
                  ld_q <= 1'b1;
                  after_q <= sscp_pkg::AF_BASE;
                  st_q <= sscp_pkg::ST_SIGNON;
                end else if (sscp_pkg::is_req_tok(b0_q)) begin
                  resp_q[0] <= b0_q;
                  resp_q[1] <= b0_q == sscp_pkg::TOK_VER ?
                               sscp_pkg::VERSION_ID :
                               b0_q == sscp_pkg::TOK_CSUM ? csum_q :
                               b1_q == sscp_pkg::ARG_DIN ? din : 8'h00;
                  resp_n_q <= 3'h2;
                  ld_q <= 1'b1;
                end
              end
            end
          end
          default: st_q <= sscp_pkg::ST_SIGNON;
        endcase
      end
    end
  end

  // settings from init packets and output commands; no reply
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= '0;
      avg_q <= '0;
      filt_q <= '0;
      scan_q <= 1'b0;
      iso_oe_n <= sscp_pkg::ISO_RST;
      chan <= '0;
      aux_out <= '0;
      exp_data <= '0;
      exp_sel <= '0;
      exp_stb <= 1'b0;
      asleep <= 1'b0;
    end else begin
      exp_stb <= 1'b0;
      asleep <= st_q == sscp_pkg::ST_SLEEP;
      if (init_ok) begin
        unique case (pkt_q)
          2'h0: mode_q[23:8] <= {b0_q, b1_q};
          2'h1: mode_q[7:0] <= b0_q;
          2'h2: {avg_q, filt_q} <= {b0_q[3:0], b1_q[1:0]};
          2'h3: scan_q <= b0_q[0];
        endcase
      end
      if (pkt_ok) begin
        if (b0_q == sscp_pkg::TOK_CTL) begin
          iso_oe_n <= ~b1_q[3:0];
          chan <= b1_q[6:4];
        end
        if (b0_q == sscp_pkg::TOK_AUX) aux_out <= b1_q;
        if (b0_q == sscp_pkg::TOK_FILT) filt_q <= b1_q[1:0];
        if (b0_q == sscp_pkg::TOK_AVG) avg_q <= b1_q[3:0];
        if (b0_q >= sscp_pkg::TOK_EXP0 && b0_q <= sscp_pkg::TOK_EXP3) begin
          exp_data <= b1_q;
          exp_sel <= 2'(b0_q - sscp_pkg::TOK_EXP0);
          exp_stb <= 1'b1;
        end
      end
    end
  end

  function automatic logic mapped(input logic [7:0] a);
    mapped = a == sscp_pkg::REG_STATUS || a == sscp_pkg::REG_MODE ||
             a == sscp_pkg::REG_SETUP || a == sscp_pkg::REG_CTRL;
  endfunction : mapped

  // one write and one read at a time; address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= sscp_pkg::AXI_OKAY;
      aw_v_q <= 1'b0;
      w_v_q <= 1'b0;
      aw_addr_q <= '0;
      wd_q <= '0;
      ws_q <= '0;
      sw_rst_q <= 1'b0;
    end else begin
      sw_rst_q <= 1'b0;
      if (awvalid && awready) begin
        aw_addr_q <= {awaddr[7:2], 2'b00};
        awready <= 1'b0;
        aw_v_q <= 1'b1;
      end
      if (wvalid && wready) begin
        wd_q <= wdata;
        ws_q <= wstrb;
        wready <= 1'b0;
        w_v_q <= 1'b1;
      end
      if (aw_v_q && w_v_q && !bvalid) begin
        aw_v_q <= 1'b0;
        w_v_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= mapped(aw_addr_q) ? sscp_pkg::AXI_OKAY : sscp_pkg::AXI_SLVERR;
        if (aw_addr_q == sscp_pkg::REG_CTRL && ws_q[0])
          sw_rst_q <= wd_q[sscp_pkg::CTRL_RST_BIT];
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  logic [31:0] rd_word;
  always_comb begin
    unique case ({araddr[7:2], 2'b00})
      sscp_pkg::REG_STATUS: rd_word = {8'h00, csum_q, 5'h00, baud_q,
                                       4'h0, asleep, st_q};
      sscp_pkg::REG_MODE: rd_word = {8'h00, mode_q};
      sscp_pkg::REG_SETUP: rd_word = {17'h00000, chan, iso_oe_n, 1'b0,
                                      scan_q, filt_q, avg_q};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= sscp_pkg::AXI_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= mapped({araddr[7:2], 2'b00}) ? sscp_pkg::AXI_OKAY :
               sscp_pkg::AXI_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_idle_sleep:
    assert property (tmo_hit && !sw_rst_q && st_q == sscp_pkg::ST_SIGNON
      |=> st_q == sscp_pkg::ST_SLEEP) else $error("no sleep after wait");
  a_wake_reply:
    assert property (ev_rx && st_q == sscp_pkg::ST_SLEEP &&
      rx_d == sscp_pkg::TOK_RESET |=> resp_q[0] == sscp_pkg::REPLY_ASLEEP
      && ld_q ##1 resp_i_q == 3'h0) else $error("bad asleep reply");
  a_baud_echo:
    assert property (ev_rx && st_q == sscp_pkg::ST_BAUD |=>
      resp_q[0] == $past(rx_d) && after_q == sscp_pkg::AF_BAUD &&
      baud_q == $past(baud_q)) else $error("baud code not echoed");
  a_echo_timeout:
    assert property (tmo_hit && !sw_rst_q && st_q == sscp_pkg::ST_ECHO |=>
      st_q == sscp_pkg::ST_SLEEP && resp_q[0] == sscp_pkg::ERR_COMM)
    else $error("no comm error");
  a_mode_back:
    assert property (init_ok && pkt_q == sscp_pkg::INIT_LAST_PKT |=>
      st_q == sscp_pkg::ST_POLL && resp_n_q == 3'h3 &&
      resp_q[0] == mode_q[23:16]) else $error("mode words not returned");
  a_poll_no_timer:
    assert property (st_q == sscp_pkg::ST_POLL |-> tmo_q == '0)
    else $error("timer runs in polled mode");
  a_bad_packet:
    assert property (ev_rx && st_q == sscp_pkg::ST_POLL && done &&
      pidx_q == 2'h2 && !sum_ok |=> st_q == sscp_pkg::ST_SIGNON &&
      resp_q[0] == sscp_pkg::ERR_PKT) else $error("bad packet accepted");
  a_cancel_stop:
    assert property (ev_rx && st_q == sscp_pkg::ST_POLL && pidx_q == 2'h0 &&
      rx_d == sscp_pkg::TOK_CANCEL |=> !tx_go_q [*2])
    else $error("reply goes on after cancel");
  a_iso_code:
    assert property (pkt_ok && b0_q == sscp_pkg::TOK_CTL |=>
      iso_oe_n == ~$past(b1_q[3:0]) && chan == $past(b1_q[6:4]))
    else $error("isolated code wrong");
  a_req_token:
    assert property (pkt_ok && sscp_pkg::is_req_tok(b0_q) |=>
      resp_q[0] == $past(b0_q) && resp_n_q == 3'h2)
    else $error("request token not resent");

  c_wake: cover property (st_q == sscp_pkg::ST_SLEEP ##1
    st_q == sscp_pkg::ST_SIGNON);
  c_signed_on: cover property (st_q == sscp_pkg::ST_INIT ##1
    st_q == sscp_pkg::ST_POLL);
  c_cancel_mid: cover property (tx_go_q ##1 resp_n_q < $past(resp_n_q));
  c_bad_pkt: cover property (st_q == sscp_pkg::ST_POLL ##1
    st_q == sscp_pkg::ST_SIGNON);
endmodule : sscp_core
`default_nettype wire

// ===== bench/sscp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sscp_host_model (
  // clock
  aclk,
  // serial lines
  rxd,
  txd
);
  input wire logic aclk;
  output logic rxd;
  input wire logic txd;
  int div = 16; // starts at the base rate
  initial rxd = 1'b1;
  // one 8N1 frame, lsb first; callers wait for each answer
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (div) @(posedge aclk);
    end
  endtask : send
  // bounded wait for a start bit, then mid-bit sampling
  task automatic recv(output logic [7:0] b);
    int n;
    n = 0;
    while (txd !== 1'b0 && n < 20000) begin
      @(posedge aclk);
      n++;
    end
    repeat (div / 2) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge aclk);
      b[i] = txd;
    end
    repeat (div) @(posedge aclk);
  endtask : recv
endmodule : sscp_host_model
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, rxd, txd, asleep;
  logic [7:0] awaddr, araddr, rb;
  logic [31:0] wdata, rdata, rv;
  logic [1:0] bresp, rresp, rr;
  logic [3:0] iso_oe_n;
  logic [2:0] chan;
  logic [3:0] wstrb;
  logic [7:0] din, aux_out, exp_data;
  logic [1:0] exp_sel;
  logic exp_stb;
  logic [9:0] exp_seen = '0;
  int n_stb = 0;
  int lows = 0;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  // packets: mode A1B2C3, avg 5, filter 2, polled
  logic [7:0] ini [12] = '{8'hA1, 8'hB2, 8'h53, 8'hC3, 8'h00, 8'hC3,
                           8'h05, 8'h02, 8'h07, 8'h00, 8'h00, 8'h00};
  sscp_core #(.TMO_CYC(2000), .DIV_BASE(16)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rxd(rxd), .txd(txd), .din(din), .iso_oe_n(iso_oe_n),
    .chan(chan), .aux_out(aux_out), .exp_data(exp_data),
    .exp_sel(exp_sel), .exp_stb(exp_stb), .asleep(asleep));
  sscp_host_model u_host (.aclk(aclk), .rxd(rxd), .txd(txd));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end
  // the expansion strobe stands one cycle, so it is caught here
  always @(posedge aclk) begin
    if (exp_stb === 1'b1) begin
      n_stb++;
      exp_seen = {exp_sel, exp_data};
    end
  end
  task automatic chk(input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic xfer(input logic [7:0] b, e);
    fork
      u_host.send(b);
      u_host.recv(rb);
    join
    chk(rb, e);
  endtask : xfer
  // three-byte packet with its sum, answer is the token and one byte
  task automatic req(input logic [7:0] t, a, e);
    u_host.send(t);
    u_host.send(a);
    xfer(8'(t + a), t);
    u_host.recv(rb);
    chk(rb, e);
  endtask : req
  // signals move right after a rising edge; handshakes are judged there
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rv = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (wready !== 1'b1);
        wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (bvalid !== 1'b1);
    rr = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic test_done();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = '0;
    din = 8'hA5;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(iso_oe_n, 4'hF);
    xfer(8'h9F, 8'h03);
    u_host.send(8'h88);
    xfer(8'h01, 8'h01);
    repeat (20) @(posedge aclk);
    u_host.div = 4;
    xfer(8'h5A, 8'h5A);
    xfer(8'h00 + 8'hFF, 8'hFF);
    u_host.send(8'h00);
    for (int i = 0; i < 11; i++) u_host.send(ini[i]);
    xfer(ini[11], 8'hA1);
    u_host.recv(rb);
    chk(rb, 8'hB2);
    u_host.recv(rb);
    chk(rb, 8'hC3);
    rd(8'h04);
    chk(rv, 32'h00A1B2C3);
    u_host.send(8'h01);
    u_host.send(8'h35);
    u_host.send(8'h36);
    repeat (20) @(posedge aclk);
    chk({chan, iso_oe_n}, 7'h3A);
    rd(8'h08);
    chk(rv, 32'h00003A25);
    req(8'h80, 8'h4C, 8'hA5);
    req(8'h86, 8'h00, sscp_pkg::VERSION_ID);
    u_host.send(8'h02);
    u_host.send(8'h5C);
    u_host.send(8'h5E);
    u_host.send(8'h07);
    u_host.send(8'h33);
    u_host.send(8'h3A);
    repeat (20) @(posedge aclk);
    chk(aux_out, 8'h5C);
    chk(n_stb, 1);
    chk(exp_seen, 10'h133);
    u_host.send(8'h87);
    u_host.send(8'h00);
    u_host.send(8'h87);
    xfer(8'h9E, 8'h87);
    repeat (60) begin
      @(posedge aclk);
      if (txd !== 1'b1) lows++;
    end
    chk(lows, 0);
    repeat (2100) @(posedge aclk);
    chk(asleep, 1'b0);
    u_host.send(8'h01);
    u_host.send(8'h00);
    xfer(8'hFF, 8'hE2);
    u_host.div = 16;
    repeat (2100) @(posedge aclk);
    chk(asleep, 1'b1);
    xfer(8'h9F, 8'h80);
    u_host.send(8'h88);
    xfer(8'h00, 8'h00);
    u_host.recv(rb);
    chk(rb, 8'hE1);
    repeat (4) @(posedge aclk);
    chk(asleep, 1'b1);
    rd(8'h10);
    chk({rr, rv}, {2'b10, 32'h0});
    wr(8'h0C, 32'h1, 4'h1);
    chk(rr, 2'b00);
    repeat (2) @(posedge aclk);
    rd(8'h00);
    chk({rr, rv[3:0]}, 6'h01);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
